// ==== limit_alert_monitor.sv ====
// Limit checking, alert status registers and alert pin of the monitor
// How it works
// [RULE1] Result word flag shows any channel currently in alert.
// [RULE2] Voltage status holds low and high bits for four inputs.
// [RULE3] Status bits accumulate; later alerts add bits, earlier ones stay. Here a limit bit drops when its channel reads back N codes inside the limit.
// [RULE4] Current status: bits 3..0 limit alerts, bits 4,5 overranges.
// [RULE5] Software should clear both overrange bits after power-up.
// [RULE6] Temperature status bit 7 marks an open diode input.
// [RULE7] Die temperature above 150 C sets bit 6, floats DACs.
// [RULE8] Temperature status bits 5..0 hold three channels' limit alerts.
// [RULE9] Writing ones to a status register clears those bits.
// [RULE10] Config write with D1 and D2 clears all, enables pin.
// [RULE11] Result above upper limit raises the high alert.
// [RULE12] Result below lower limit raises the low alert.
// [RULE13] Alert drops once a later result is back in range.
// [RULE14] Status is refreshed on every conversion result.
// [RULE15] Alert releases only N codes inside the limit.
// [RULE16] Hysteresis near full scale keeps alerts from releasing.
// [RULE17] Temperature limit bit 11 reads zero while diode is open.
// [RULE18] Overrange status stays until software clears it.
// [RULE19] Hysteresis resets to 8, or 32 for temperature channels.
// [RULE20] Every channel has its own hysteresis for its limits.
// [RULE21] Hysteresis of FFF turns limits into min/max recorders.
// [RULE22] Upper limits reset to full code, lower limits to zero.
// [RULE23] Result word: flag, channel id, four MSBs, then eight LSBs.
// [RULE24] Recorder overwrites extremes and raises no limit alert.
`include "limit_alert_defines.svh"
module limit_alert_monitor #(
  parameter int unsigned RESULT_W = `RESULT_W
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic conv_valid_i,
  input wire logic [3:0] conv_chan_i,
  input wire logic [RESULT_W-1:0] conv_data_i,
  input wire logic current_channel_one_overrange_i,
  input wire logic current_channel_two_overrange_i,
  input wire logic diode_sensor_pins_one_open_i,
  input wire logic diode_sensor_pins_two_open_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output limit_alert_pkg::reg_word_t reg_rdata_o,
  output logic alert_o,
  output logic dac_hiz_o
);
  if (RESULT_W != `RESULT_W) begin : g_bad_width
    $error("limit_alert_monitor supports only 12-bit results");
  end

  limit_alert_pkg::code_t upper [`NUM_CH];
  limit_alert_pkg::code_t lower [`NUM_CH];
  limit_alert_pkg::code_t hyst [`NUM_CH];
  limit_alert_pkg::code_t next_upper [`NUM_CH];
  limit_alert_pkg::code_t next_lower [`NUM_CH];
  logic [`NUM_CH-1:0] alert_hi;
  logic [`NUM_CH-1:0] alert_lo;
  logic [`NUM_CH-1:0] next_alert_hi;
  logic [`NUM_CH-1:0] next_alert_lo;
  logic [`NUM_CH-1:0] conv_hit;
  logic [2*`NUM_CH-1:0] lim_set;
  logic [2*`NUM_CH-1:0] lim_drop;
  limit_alert_pkg::status_t volt_stat;
  limit_alert_pkg::status_t curr_stat;
  limit_alert_pkg::status_t temp_stat;
  limit_alert_pkg::status_t volt_clr;
  limit_alert_pkg::status_t curr_clr;
  limit_alert_pkg::status_t temp_clr;
  limit_alert_pkg::reg_word_t config_word;
  logic alert_pin_en;
  limit_alert_pkg::code_t last_result;
  logic [3:0] last_chan;
  logic [1:0] ovr_s;
  logic [1:0] open_s;
  logic cfg_wr;
  logic clear_all;
  logic any_alert;
  logic overtemp_hit;
  logic lim_wr;
  logic [3:0] lim_ch;
  limit_alert_pkg::limit_sel_t lim_sel;

  function automatic logic limit_hit_f(input logic [7:0] a);
    int off;
    off = int'(a) - int'(`ADDR_LIMIT_BASE);
    return (off >= 0) && (off < `NUM_CH * `LIMIT_STRIDE);
  endfunction

  function automatic logic [3:0] limit_ch_f(input logic [7:0] a);
    logic [7:0] off;
    off = a - `ADDR_LIMIT_BASE;
    return 4'(off / 8'(`LIMIT_STRIDE));
  endfunction

  function automatic limit_alert_pkg::limit_sel_t limit_sel_f(
      input logic [7:0] a);
    logic [7:0] off;
    off = a - `ADDR_LIMIT_BASE;
    return limit_alert_pkg::limit_sel_t'(2'(off % 8'(`LIMIT_STRIDE)));
  endfunction

  // Overrange comparators and diode detectors are asynchronous
  sync2 #(.W(2)) u_ovr_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i({current_channel_two_overrange_i, current_channel_one_overrange_i}),
    .q_o(ovr_s)
  );

  sync2 #(.W(2)) u_open_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i({diode_sensor_pins_two_open_i, diode_sensor_pins_one_open_i}),
    .q_o(open_s)
  );

  limit_check_if chk_if [`NUM_CH] ();

  for (genvar g = 0; g < `NUM_CH; g++) begin : g_chk
    // [RULE20] own limits and hysteresis
    assign chk_if[g].result = conv_data_i;
    assign chk_if[g].upper = upper[g];
    assign chk_if[g].lower = lower[g];
    assign chk_if[g].hyst = hyst[g];
    assign chk_if[g].alert_hi = alert_hi[g];
    assign chk_if[g].alert_lo = alert_lo[g];
    assign next_upper[g] = chk_if[g].next_upper;
    assign next_lower[g] = chk_if[g].next_lower;
    assign next_alert_hi[g] = chk_if[g].next_alert_hi;
    assign next_alert_lo[g] = chk_if[g].next_alert_lo;
    assign conv_hit[g] = conv_valid_i && (conv_chan_i == 4'(g));
    // [RULE14] refresh on each conversion
    assign lim_set[2*g] = conv_hit[g] && next_alert_lo[g];
    assign lim_set[2*g+1] = conv_hit[g] && next_alert_hi[g];
    // [RULE13] back in range drops bit
    assign lim_drop[2*g] = conv_hit[g] && !next_alert_lo[g];
    assign lim_drop[2*g+1] = conv_hit[g] && !next_alert_hi[g];
    limit_checker u_chk (
      .chk(chk_if[g])
    );
  end

  assign lim_wr = reg_wr_i && limit_hit_f(reg_addr_i);
  assign lim_ch = limit_ch_f(reg_addr_i);
  assign lim_sel = limit_sel_f(reg_addr_i);
  assign cfg_wr = reg_wr_i && (reg_addr_i == `ADDR_CONFIG);
  // [RULE10] both clear bits written
  assign clear_all = cfg_wr && reg_wdata_i[`CFG_CLR_A_BIT]
    && reg_wdata_i[`CFG_CLR_B_BIT];

  // [RULE9] write-one clear, FF clears all
  always_comb begin
    volt_clr = '0;
    curr_clr = '0;
    temp_clr = '0;
    if (clear_all) begin
      volt_clr = 8'hFF;
      curr_clr = 8'hFF;
      temp_clr = 8'hFF;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_VOLT_STAT) volt_clr = reg_wdata_i[7:0];
      if (reg_addr_i == `ADDR_CURR_STAT) curr_clr = reg_wdata_i[7:0];
      if (reg_addr_i == `ADDR_TEMP_STAT) temp_clr = reg_wdata_i[7:0];
    end
  end

  // Signed compare so sub-zero die readings never trip it
  // [RULE7] die overtemperature detect
  assign overtemp_hit = conv_hit[`CH_DIE]
    && ($signed(conv_data_i) > $signed(13'(`OVERTEMP_CODE)));

  // Limits and alert state; a register write beats a conversion
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < `NUM_CH; c++) begin
      if (reset_i) begin
        // [RULE22] full-scale and zero limits
        upper[c] <= `UPPER_RESET;
        lower[c] <= `LOWER_RESET;
        // [RULE19] hysteresis power-up values
        hyst[c] <= (c >= `CH_TEMP0) ? `HYST_RESET_TEMP : `HYST_RESET_PLAIN;
        alert_hi[c] <= 1'b0;
        alert_lo[c] <= 1'b0;
      end else begin
        if (lim_wr && lim_ch == 4'(c) && lim_sel == limit_alert_pkg::SEL_UPPER)
          upper[c] <= reg_wdata_i[11:0];
        else if (conv_hit[c])
          upper[c] <= next_upper[c];
        if (lim_wr && lim_ch == 4'(c) && lim_sel == limit_alert_pkg::SEL_LOWER)
          lower[c] <= reg_wdata_i[11:0];
        else if (conv_hit[c])
          lower[c] <= next_lower[c];
        if (lim_wr && lim_ch == 4'(c) && lim_sel == limit_alert_pkg::SEL_HYST)
          hyst[c] <= reg_wdata_i[11:0];
        if (conv_hit[c]) begin
          alert_hi[c] <= next_alert_hi[c];
          alert_lo[c] <= next_alert_lo[c];
        end
      end
    end
  end

  // Set wins over any clear in the same cycle
  // [RULE3] accumulate alert bits
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      volt_stat <= 8'h00;
    end else begin
      // [RULE2] four voltage pairs
      volt_stat <= (volt_stat & ~volt_clr & ~lim_drop[7:0]) | lim_set[7:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      curr_stat <= 8'h00;
    end else begin
      // [RULE4] current limit pairs
      curr_stat[3:0] <= (curr_stat[3:0] & ~curr_clr[3:0] & ~lim_drop[11:8])
        | lim_set[11:8];
      // [RULE18] overrange stays until written
      curr_stat[`STAT_OVR1_BIT] <= (curr_stat[`STAT_OVR1_BIT]
        && !curr_clr[`STAT_OVR1_BIT]) || ovr_s[0];
      curr_stat[`STAT_OVR2_BIT] <= (curr_stat[`STAT_OVR2_BIT]
        && !curr_clr[`STAT_OVR2_BIT]) || ovr_s[1];
      curr_stat[7:6] <= 2'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      temp_stat <= 8'h00;
    end else begin
      // [RULE8] three temperature pairs
      temp_stat[5:0] <= (temp_stat[5:0] & ~temp_clr[5:0] & ~lim_drop[17:12])
        | lim_set[17:12];
      temp_stat[`STAT_OVERTEMP_BIT] <= (temp_stat[`STAT_OVERTEMP_BIT]
        && !temp_clr[`STAT_OVERTEMP_BIT]) || overtemp_hit;
      // [RULE6] open diode flag
      temp_stat[`STAT_OPEN_BIT] <= (temp_stat[`STAT_OPEN_BIT]
        && !temp_clr[`STAT_OPEN_BIT]) || (|open_s);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      config_word <= `CONFIG_RESET;
      alert_pin_en <= 1'b0;
    end else if (cfg_wr) begin
      config_word <= reg_wdata_i;
      alert_pin_en <= clear_all;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      last_result <= 12'h000;
      last_chan <= 4'h0;
    end else if (conv_valid_i) begin
      last_result <= conv_data_i;
      last_chan <= conv_chan_i;
    end
  end

  // [RULE1] flag covers every channel
  assign any_alert = (|volt_stat) || (|curr_stat) || (|temp_stat);
  assign alert_o = alert_pin_en && any_alert;
  // [RULE7] overtemperature floats DACs
  assign dac_hiz_o = temp_stat[`STAT_OVERTEMP_BIT];

  // Reads have no side effect; unmapped offsets read zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
      if (reg_addr_i == `ADDR_RESULT)
        // [RULE23] flag, id, result
        reg_rdata_o <= {any_alert, last_chan[2:0], last_result};
      else if (reg_addr_i == `ADDR_VOLT_STAT)
        reg_rdata_o <= {8'h00, volt_stat};
      else if (reg_addr_i == `ADDR_CURR_STAT)
        reg_rdata_o <= {8'h00, curr_stat};
      else if (reg_addr_i == `ADDR_TEMP_STAT)
        reg_rdata_o <= {8'h00, temp_stat};
      else if (reg_addr_i == `ADDR_CONFIG)
        reg_rdata_o <= config_word;
      else if (limit_hit_f(reg_addr_i)) begin
        unique case (lim_sel)
          limit_alert_pkg::SEL_UPPER:
            reg_rdata_o <= {4'h0, upper[lim_ch]};
          limit_alert_pkg::SEL_LOWER:
            reg_rdata_o <= {4'h0, lower[lim_ch]};
          limit_alert_pkg::SEL_HYST:
            reg_rdata_o <= {4'h0, hyst[lim_ch]};
          default:
            reg_rdata_o <= 16'h0000;
        endcase
        // [RULE17] open diode reads bit 11 low
        if (lim_sel != limit_alert_pkg::SEL_HYST
            && ((lim_ch == 4'(`CH_TEMP0) && open_s[0])
            || (lim_ch == 4'(`CH_TEMP1) && open_s[1])))
          reg_rdata_o[`OPEN_FLAG_BIT] <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic conv_ok;
  assign conv_ok = conv_valid_i && (conv_chan_i < 4'(`NUM_CH));

  a_upper_raise: assert property ( // [RULE11]
    conv_ok && hyst[conv_chan_i] != `HYST_RECORDER
    && conv_data_i > upper[conv_chan_i]
    |=> alert_hi[$past(conv_chan_i)] && any_alert)
    else $error("upper crossing did not raise alert");

  a_lower_raise: assert property ( // [RULE12]
    conv_ok && hyst[conv_chan_i] != `HYST_RECORDER
    && conv_data_i < lower[conv_chan_i]
    |=> alert_lo[$past(conv_chan_i)])
    else $error("lower crossing did not raise alert");

  a_hyst_hold: assert property ( // [RULE15]
    conv_ok && alert_hi[conv_chan_i] && hyst[conv_chan_i] != `HYST_RECORDER
    && conv_data_i <= upper[conv_chan_i]
    && int'(conv_data_i) + int'(hyst[conv_chan_i]) > int'(upper[conv_chan_i])
    |=> alert_hi[$past(conv_chan_i)])
    else $error("alert released inside hysteresis band");

  a_auto_release: assert property ( // [RULE13]
    conv_ok && hyst[conv_chan_i] != `HYST_RECORDER
    && int'(conv_data_i) + int'(hyst[conv_chan_i]) <= int'(upper[conv_chan_i])
    |=> !alert_hi[$past(conv_chan_i)])
    else $error("alert did not release after return");

  a_recorder_max: assert property ( // [RULE24]
    conv_ok && hyst[conv_chan_i] == `HYST_RECORDER && !reg_wr_i
    && conv_data_i > upper[conv_chan_i]
    |=> upper[$past(conv_chan_i)] == $past(conv_data_i)
    && !alert_hi[$past(conv_chan_i)])
    else $error("recorder did not capture maximum");

  a_w1c_volt: assert property ( // [RULE9]
    reg_wr_i && reg_addr_i == `ADDR_VOLT_STAT && !conv_valid_i
    |=> volt_stat == ($past(volt_stat) & ~$past(reg_wdata_i[7:0])))
    else $error("voltage status write-one clear wrong");

  a_clear_all: assert property ( // [RULE10]
    clear_all && !conv_valid_i && ovr_s == 2'h0 && open_s == 2'h0
    |=> volt_stat == 8'h00 && curr_stat == 8'h00 && temp_stat == 8'h00
    && alert_pin_en && !alert_o)
    else $error("configuration clear did not clear status");

  a_ovr_sticky: assert property ( // [RULE18]
    curr_stat[`STAT_OVR1_BIT] && !curr_clr[`STAT_OVR1_BIT]
    |=> curr_stat[`STAT_OVR1_BIT] [*1])
    else $error("overrange bit cleared by itself");

  a_overtemp_hiz: assert property ( // [RULE7]
    overtemp_hit |=> dac_hiz_o && temp_stat[`STAT_OVERTEMP_BIT])
    else $error("overtemperature did not float DACs");

  a_open_flag: assert property ( // [RULE6]
    $rose(open_s[0]) |=> temp_stat[`STAT_OPEN_BIT])
    else $error("open diode not flagged");

  a_flag_read: assert property ( // [RULE1]
    reg_rd_i && reg_addr_i == `ADDR_RESULT
    |=> reg_rdata_o[`FLAG_BIT] == $past(any_alert))
    else $error("result flag does not match status");

  a_reset_vals: assert property ( // [RULE22]
    $fell(reset_i) |-> upper[0] == `UPPER_RESET && lower[0] == `LOWER_RESET
    && hyst[0] == `HYST_RESET_PLAIN && hyst[`CH_DIE] == `HYST_RESET_TEMP)
    else $error("limit or hysteresis reset value wrong");

  c_recorder: cover property (
    conv_ok && hyst[conv_chan_i] == `HYST_RECORDER
    && conv_data_i < lower[conv_chan_i]);
  c_clear_all: cover property (clear_all ##1 alert_o [*2]);
  c_overtemp: cover property (overtemp_hit ##1 dac_hiz_o);
  c_release: cover property (alert_hi[0] ##[1:20] !alert_hi[0]);
endmodule // limit_alert_monitor

// ==== limit_alert_defines.svh ====
// Register offsets, field positions, reset values and limits of the monitor
`ifndef LIMIT_ALERT_DEFINES_SVH
`define LIMIT_ALERT_DEFINES_SVH
`define RESULT_W 12
`define NUM_CH 9
`define CH_CURR0 4
`define CH_TEMP0 6
`define CH_TEMP1 7
`define CH_DIE 8
`define ADDR_RESULT 8'h01
`define ADDR_VOLT_STAT 8'h04
`define ADDR_CURR_STAT 8'h05
`define ADDR_TEMP_STAT 8'h06
`define ADDR_CONFIG 8'h09
`define ADDR_LIMIT_BASE 8'h18
`define LIMIT_STRIDE 3
`define CFG_CLR_A_BIT 1
`define CFG_CLR_B_BIT 2
`define STAT_OVR1_BIT 4
`define STAT_OVR2_BIT 5
`define STAT_OVERTEMP_BIT 6
`define STAT_OPEN_BIT 7
`define FLAG_BIT 15
`define OPEN_FLAG_BIT 11
`define HYST_RESET_PLAIN 12'h008
`define HYST_RESET_TEMP 12'h020
`define HYST_RECORDER 12'hFFF
`define UPPER_RESET 12'hFFF
`define LOWER_RESET 12'h000
`define CONFIG_RESET 16'h0000
`define OVERTEMP_DEG 150
`define TEMP_LSB_PER_DEG 4
`define OVERTEMP_CODE (`OVERTEMP_DEG * `TEMP_LSB_PER_DEG)
`endif

// ==== limit_alert_pkg.sv ====
// Shared types of the limit and alert monitor
package limit_alert_pkg;
  typedef logic [11:0] code_t;
  typedef logic [7:0] status_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {
    SEL_LOWER = 2'b00,
    SEL_UPPER = 2'b01,
    SEL_HYST = 2'b10
  } limit_sel_t;
endpackage

// ==== limit_check_if.sv ====
// Per-channel link between the register owner and its limit checker
interface limit_check_if;
  limit_alert_pkg::code_t result;
  limit_alert_pkg::code_t upper;
  limit_alert_pkg::code_t lower;
  limit_alert_pkg::code_t hyst;
  logic alert_hi;
  logic alert_lo;
  limit_alert_pkg::code_t next_upper;
  limit_alert_pkg::code_t next_lower;
  logic next_alert_hi;
  logic next_alert_lo;
  modport calc (input result, upper, lower, hyst, alert_hi, alert_lo,
    output next_upper, next_lower, next_alert_hi, next_alert_lo);
  modport owner (output result, upper, lower, hyst, alert_hi, alert_lo,
    input next_upper, next_lower, next_alert_hi, next_alert_lo);
endinterface

// ==== sync2.sv ====
// Two-flop synchroniser for pin levels
module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // sync2

// ==== limit_checker.sv ====
// Next limit, recorder and alert state of one channel for one conversion
`include "limit_alert_defines.svh"
module limit_checker (
  limit_check_if.calc chk
);
  logic recorder;
  logic [12:0] res_x;
  logic [12:0] up_x;
  logic [12:0] lo_x;
  logic [12:0] hy_x;
  assign res_x = {1'b0, chk.result};
  assign up_x = {1'b0, chk.upper};
  assign lo_x = {1'b0, chk.lower};
  assign hy_x = {1'b0, chk.hyst};
  // [RULE21] recorder mode select
  assign recorder = (chk.hyst == `HYST_RECORDER);
  always_comb begin
    chk.next_upper = chk.upper;
    chk.next_lower = chk.lower;
    chk.next_alert_hi = chk.alert_hi;
    chk.next_alert_lo = chk.alert_lo;
    if (recorder) begin
      // [RULE24] track extremes, no alerts
      if (chk.result > chk.upper) chk.next_upper = chk.result;
      if (chk.result < chk.lower) chk.next_lower = chk.result;
      chk.next_alert_hi = 1'b0;
      chk.next_alert_lo = 1'b0;
    end else begin
      // [RULE11] strictly above upper
      if (chk.result > chk.upper) begin
        chk.next_alert_hi = 1'b1;
      // [RULE15] release N below upper
      end else if (res_x + hy_x <= up_x) begin
        chk.next_alert_hi = 1'b0;
      end
      // [RULE12] strictly below lower
      if (chk.result < chk.lower) begin
        chk.next_alert_lo = 1'b1;
      // [RULE16] large N never reached
      end else if (res_x >= lo_x + hy_x) begin
        chk.next_alert_lo = 1'b0;
      end
    end
  end
endmodule // limit_checker

// ==== bus_master_model.sv ====
// Register port master that stands in for the serial-bus host
module bus_master_model (
  input wire logic core_clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire limit_alert_pkg::reg_word_t reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
  end
  // Strobe held across exactly one rising edge
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
  endtask
  // Data sampled a cycle and a half after the taking edge
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_i;
  endtask
  task automatic init_after_power_up();
    write_reg(8'h05, 16'h0030);
  endtask
endmodule // bus_master_model

// ==== limit_alert_monitor_tb.sv ====
// Self-checking bench of the limit and alert monitor
`include "limit_alert_defines.svh"
module limit_alert_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, reset_i, conv_valid_i, ovr1, ovr2, open1, open2;
  logic reg_wr, reg_rd, alert_o, dac_hiz_o;
  logic [3:0] conv_chan_i;
  logic [11:0] conv_data_i;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, rv;
  limit_alert_pkg::reg_word_t reg_rdata;
  int fails = 0;
  int check_count = 0;
  limit_alert_monitor i_limit_alert_monitor (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .conv_valid_i(conv_valid_i),
    .conv_chan_i(conv_chan_i), .conv_data_i(conv_data_i),
    .current_channel_one_overrange_i(ovr1),
    .current_channel_two_overrange_i(ovr2),
    .diode_sensor_pins_one_open_i(open1),
    .diode_sensor_pins_two_open_i(open2), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .alert_o(alert_o), .dac_hiz_o(dac_hiz_o));
  bus_master_model i_bus_master_model (.core_clk_i(core_clk_i),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] lim(input int ch, input int k);
    return 8'h18 + 8'(3 * ch + k);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_bus_master_model.write_reg(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    i_bus_master_model.read_reg(a, rv);
    check(rv, exp);
  endtask
  task automatic conv(input logic [3:0] ch, input logic [11:0] d);
    @(negedge core_clk_i);
    conv_chan_i = ch;
    conv_data_i = d;
    conv_valid_i = 1'b1;
    @(negedge core_clk_i);
    conv_valid_i = 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    {reset_i, conv_valid_i, ovr1, ovr2, open1, open2} = 6'b100000;
    conv_chan_i = 4'h0;
    conv_data_i = 12'h000;
    repeat (3) @(negedge core_clk_i);
    reset_i = 1'b0;
    rd(lim(0, 2), 16'(`HYST_RESET_PLAIN));
    rd(lim(6, 2), 16'(`HYST_RESET_TEMP));
    rd(lim(8, 2), 16'(`HYST_RESET_TEMP));
    rd(lim(5, 1), 16'(`UPPER_RESET));
    rd(lim(5, 0), 16'(`LOWER_RESET));
    rd(8'h40, 16'h0000);
    i_bus_master_model.init_after_power_up();
    $display("test reset done");
    wr(lim(0, 1), 16'h0800);
    wr(lim(1, 1), 16'h0800);
    wr(lim(0, 0), 16'h0100);
    conv(4'h1, 12'h800);
    rd(8'h04, 16'h0000);
    conv(4'h0, 12'h801);
    conv(4'h1, 12'h801);
    rd(8'h04, 16'h000A);
    rd(8'h01, 16'h9801);
    check(16'(alert_o), 16'h0000);
    $display("test limits done");
    conv(4'h1, 12'h7F9);
    rd(8'h04, 16'h000A);
    conv(4'h1, 12'h7F8);
    rd(8'h04, 16'h0002);
    conv(4'h0, 12'h0FF);
    rd(8'h04, 16'h0001);
    rd(8'h01, 16'h80FF);
    conv(4'h1, 12'h801);
    rd(8'h04, 16'h0009);
    wr(8'h04, 16'h0008);
    rd(8'h04, 16'h0001);
    wr(8'h04, 16'h00FF);
    rd(8'h04, 16'h0000);
    $display("test hysteresis done");
    wr(lim(3, 1), 16'h0700);
    wr(lim(3, 2), 16'h077D);
    conv(4'h3, 12'h701);
    conv(4'h3, 12'h000);
    rd(8'h04, 16'h0080);
    conv(4'h2, 12'h7FC);
    rd(lim(2, 2), 16'(`HYST_RESET_PLAIN));
    wr(8'h09, 16'h0006);
    rd(8'h04, 16'h0000);
    rd(8'h09, 16'h0006);
    check(16'(alert_o), 16'h0000);
    wr(lim(4, 0), 16'h0010);
    conv(4'h4, 12'h005);
    rd(8'h05, 16'h0001);
    check(16'(alert_o), 16'h0001);
    $display("test config done");
    @(negedge core_clk_i);
    {ovr1, ovr2} = 2'b11;
    repeat (4) @(negedge core_clk_i);
    {ovr1, ovr2} = 2'b00;
    repeat (4) @(negedge core_clk_i);
    conv(4'h4, 12'h100);
    rd(8'h05, 16'h0030);
    wr(8'h05, 16'h0030);
    rd(8'h05, 16'h0000);
    $display("test overrange done");
    open2 = 1'b1;
    repeat (4) @(negedge core_clk_i);
    rd(8'h06, 16'h0080);
    rd(lim(7, 1), 16'h07FF);
    rd(lim(6, 1), 16'h0FFF);
    conv(4'h8, 12'h258);
    rd(8'h06, 16'h0080);
    check(16'(dac_hiz_o), 16'h0000);
    conv(4'h8, 12'h259);
    rd(8'h06, 16'h00C0);
    check(16'(dac_hiz_o), 16'h0001);
    wr(lim(7, 1), 16'h0100);
    conv(4'h7, 12'h101);
    rd(8'h06, 16'h00C8);
    open2 = 1'b0;
    // Let the synchroniser drain so the clear is not beaten by the set
    repeat (4) @(negedge core_clk_i);
    wr(8'h06, 16'h0080);
    rd(8'h06, 16'h0048);
    open1 = 1'b1;
    repeat (4) @(negedge core_clk_i);
    rd(8'h06, 16'h00C8);
    rd(lim(6, 1), 16'h07FF);
    open1 = 1'b0;
    $display("test temperature done");
    wr(lim(2, 2), 16'(`HYST_RECORDER));
    wr(lim(2, 1), 16'h0000);
    wr(lim(2, 0), 16'h0FFF);
    conv(4'h2, 12'h500);
    conv(4'h2, 12'h300);
    rd(lim(2, 1), 16'h0500);
    rd(lim(2, 0), 16'h0300);
    rd(8'h04, 16'h0000);
    $display("test recorder done");
    complete_run();
  end
endmodule // limit_alert_monitor_tb
